// file: kbchp_pkg.sv
/*
 * Shared constants and types for the keyboard controller host port and
 * core state block: status and program-state-word fields, vectors, RAM
 * layout, host decode addresses and firmware operation codes.
 * Assumes nothing of its surroundings; included by package scope only.
 */
package kbchp_pkg;

	// Host status register field positions
	localparam int STS_OBF = 0;
	localparam int STS_IBF = 1;
	localparam int STS_F0  = 2;
	localparam int STS_CD  = 3;
	localparam int STS_USR = 4;

	// Program state word field positions
	localparam int PSW_BS  = 4;
	localparam int PSW_TOP = 4;
	localparam logic [7:0] PSW_RST = 8'h08;

	// Program memory vectors, 2k words
	localparam int PC_W = 11;
	localparam logic [10:0] VEC_RESET = 11'h000;
	localparam logic [10:0] VEC_IBF   = 11'h003;
	localparam logic [10:0] VEC_TMR   = 11'h007;

	// Data RAM layout
	localparam int RAM_DEPTH = 256;
	localparam logic [7:0] BANK0_BASE = 8'h00;
	localparam logic [7:0] BANK1_BASE = 8'h18;
	localparam logic [7:0] STACK_BASE = 8'h08;

	// Host decode addresses for the internal select
	localparam logic [9:0] KBC_DATA_ADDR = 10'h060;
	localparam logic [9:0] KBC_CMD_ADDR  = 10'h064;

	// Port two special pins and port reset level
	localparam int P2_RPL = 4;
	localparam int P2_WRF = 5;
	localparam int P2_DRQ = 6;
	localparam int P2_ACK = 7;
	localparam logic [7:0] PORT_RST = 8'hFF;

	// Width of the synchronised pin bundle
	localparam int SYNC_W = 38;

	// Firmware operations presented on the op port
	typedef enum logic [4:0] {
		OP_NOP    = 5'h00,
		OP_BUFOUT = 5'h01,
		OP_BUFIN  = 5'h02,
		OP_MOVSTS = 5'h03,
		OP_F0CLR  = 5'h04,
		OP_F0CPL  = 5'h05,
		OP_ENFLG  = 5'h06,
		OP_ENDMA  = 5'h07,
		OP_SELRB0 = 5'h08,
		OP_SELRB1 = 5'h09,
		OP_REGWR  = 5'h0A,
		OP_REGRD  = 5'h0B,
		OP_RAMWR  = 5'h0C,
		OP_RAMRD  = 5'h0D,
		OP_PSWWR  = 5'h0E,
		OP_PSWRD  = 5'h0F,
		OP_P1WR   = 5'h10,
		OP_P2WR   = 5'h11,
		OP_P1RD   = 5'h12,
		OP_P2RD   = 5'h13,
		OP_CALL   = 5'h14,
		OP_RET    = 5'h15,
		OP_EXIT_WITH_FLAGS_RESTORE   = 5'h16,
		OP_JMP    = 5'h17,
		OP_INCPC  = 5'h18,
		OP_IBFIE  = 5'h19,
		OP_TMRIE  = 5'h1A
	} kbchp_op_type;

	// Host access sequencer states
	typedef enum logic [2:0] {
		HS_IDLE  = 3'h1,
		HS_READ  = 3'h2,
		HS_WRITE = 3'h4
	} kbchp_hs_type;

endpackage

// file: kbchp_sync.sv
/*
 * Two-stage synchroniser for a bundle of asynchronous inputs.
 * Assumes each bit is a level; multi-bit words are only read while a
 * qualifying strobe says they are stable.
 */
`timescale 1ns/1ps

module kbchp_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Raw and synchronised levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q   <= INIT;
			sync_out <= INIT;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// file: kbchp_host_port.sv
/*
 * Keyboard controller host byte port with the controller's core state:
 * reply and command buffers, host status, port two handshake pins,
 * interrupt vectoring, PC, program state word, data RAM with banks and
 * stack, and sixteen quasi-bidirectional port lines.
 * Assumes an outside sequencer issues one firmware op per valid cycle
 * and advances the PC before a call; host pins are asynchronous.
 */
`timescale 1ns/1ps

// Overview of operation
// - Reply buffer loads only from buffer_output op; host data read returns it.
// - Host writes fill the command buffer; buffer_input op hands it to firmware.
// - Host status is read-only: reply, write, flag, command/data, user nibble.
// - Reply-pending sets on buffer load, clears when host reads the buffer.
// - Host-write-pending sets on host write, clears on buffer_input op.
// - Status bit 2 is a firmware flag, cleared or toggled; host only sees it.
// - Each host write copies address line A2, or 0 under acknowledge, into the command/data flag.
// - Status bits 4-7 load from the move-to-flags op only.
// - Selected: read A2=0 data, A2=1 status; write loads buffer; else nothing.
// - Option bit picks internal 60h/64h decode or external select pin.
// - Flag mode puts reply flag on pin 24 and write flag on pin 25.
// - Latched pin value masks flags; pin 25 complemented; zero forces low.
// - DMA mode: writing 1 to pin 26 raises request; pin 27 acknowledges.
// - Request drops on acknowledge or on repeating the DMA enable op.
// - PC addresses 2k program space and resets to 000h.
// - Pending host write with its interrupt enabled calls address 003h.
// - Timer overflow with interrupt enabled calls 007h; the call clears it.
// - Bank 0 at 0h-7h, bank 1 at 18h-1Fh; bank 0 after reset.
// - Stack is eight two-byte entries at 8h-17h; index 0 uses 8h and 9h.
// - State word: carry, half carry, flag, bank, reserved, stack index.
// - Bank bit reads 0 for bank 0 and 1 for bank 1.
// - Calls push PC and top state nibble; only flag-restoring exit restores.
// - Port lines drive low on 0, float weakly high on 1; reset to 1.
// - Port reads return the synchronised pin level.
module kbchp_host_port (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Host bus pins
	input  wire logic [9:0]            host_addr,
	input  wire logic                  host_aen,
	input  wire logic                  host_cs_n,
	input  wire logic                  host_ior_n,
	input  wire logic                  host_iow_n,
	input  wire logic [7:0]            host_din,
	output logic      [7:0]            host_dout,
	output logic                       host_doe,
	// Select source option
	input  wire logic                  cs_decode_en,
	// Firmware op port
	input  wire logic                  fw_op_valid,
	input  wire kbchp_pkg::kbchp_op_type fw_op,
	input  wire logic [10:0]           fw_addr,
	input  wire logic [7:0]            fw_data,
	output logic      [7:0]            fw_rdata,
	output logic      [10:0]           pc,
	output logic      [7:0]            program_state_word,
	output logic                       irq_call,
	// Timer event
	input  wire logic                  timer_ovf,
	// Port lines
	input  wire logic [7:0]            p1_in,
	output logic      [7:0]            p1_out,
	output logic      [7:0]            p1_oe,
	input  wire logic [7:0]            p2_in,
	output logic      [7:0]            p2_out,
	output logic      [7:0]            p2_oe
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisation

	logic [kbchp_pkg::SYNC_W-1:0] raw_in;
	logic [kbchp_pkg::SYNC_W-1:0] syn;
	logic                         cs_n_s;
	logic                         rd_n_s;
	logic                         wr_n_s;
	logic                         aen_s;
	logic [9:0]                   addr_s;
	logic [7:0]                   din_s;
	logic [7:0]                   p1_s;
	logic [7:0]                   p2_s;

	assign raw_in = {host_cs_n, host_ior_n, host_iow_n, host_aen,
		host_addr, host_din, p1_in, p2_in};

	// Strobes, address and data share one synchroniser
	kbchp_sync #(
		.W    (kbchp_pkg::SYNC_W),
		.INIT ({kbchp_pkg::SYNC_W{1'b1}})
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (raw_in),
		.sync_out (syn)
	);

	assign {cs_n_s, rd_n_s, wr_n_s, aen_s, addr_s, din_s, p1_s, p2_s} = syn;

	////////////////////////////////////////////////////////////////////////
	// Host access decode and sequencer

	kbchp_pkg::kbchp_hs_type hs_q;
	logic       dma_en_q;
	logic       flags_en_q;
	logic       dack_act;
	logic       int_sel;
	logic       sel;
	logic       a2_eff;
	logic       rd_done;
	logic       wr_done;
	logic       rd_a2_q;
	logic       wr_a2_q;
	logic [7:0] wr_byte_q;

	// Acknowledge acts as a select for data transfers
	assign dack_act = dma_en_q & ~p2_s[kbchp_pkg::P2_ACK];
	assign int_sel  = ~aen_s & (addr_s == kbchp_pkg::KBC_DATA_ADDR |
		addr_s == kbchp_pkg::KBC_CMD_ADDR);
	assign sel      = (cs_decode_en ? int_sel : ~cs_n_s) | dack_act;
	assign a2_eff   = addr_s[2] & ~dack_act;
	assign rd_done  = (hs_q == kbchp_pkg::HS_READ) & rd_n_s;
	assign wr_done  = (hs_q == kbchp_pkg::HS_WRITE) & wr_n_s;

	// One state per access; action is taken on the trailing edge only
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hs_q <= kbchp_pkg::HS_IDLE;
		end else begin
			unique case (hs_q)
				kbchp_pkg::HS_IDLE: begin
					if (sel & ~rd_n_s) begin
						hs_q <= kbchp_pkg::HS_READ;
					end else if (sel & ~wr_n_s) begin
						hs_q <= kbchp_pkg::HS_WRITE;
					end
				end
				kbchp_pkg::HS_READ: begin
					if (rd_n_s) begin
						hs_q <= kbchp_pkg::HS_IDLE;
					end
				end
				kbchp_pkg::HS_WRITE: begin
					if (wr_n_s) begin
						hs_q <= kbchp_pkg::HS_IDLE;
					end
				end
				default: begin
					hs_q <= kbchp_pkg::HS_IDLE;
				end
			endcase
		end
	end

	// Latch address bit and byte while the strobe is low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_a2_q   <= 1'b0;
			wr_a2_q   <= 1'b0;
			wr_byte_q <= 8'h00;
		end else begin
			if (hs_q == kbchp_pkg::HS_IDLE & sel & ~rd_n_s) begin
				rd_a2_q <= a2_eff;
			end
			if (~wr_n_s & (hs_q == kbchp_pkg::HS_WRITE |
				(hs_q == kbchp_pkg::HS_IDLE & sel & rd_n_s))) begin
				wr_a2_q   <= a2_eff;
				wr_byte_q <= din_s;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Buffers and host status

	logic       op_bufout;
	logic       op_bufin;
	logic [7:0] reply_q;
	logic [7:0] cmd_q;
	logic       obf_q;
	logic       ibf_q;
	logic       f0_q;
	logic       cd_q;
	logic [3:0] usr_q;
	logic [7:0] status;

	assign op_bufout = fw_op_valid & (fw_op == kbchp_pkg::OP_BUFOUT);
	assign op_bufin  = fw_op_valid & (fw_op == kbchp_pkg::OP_BUFIN);
	assign status    = {usr_q, cd_q, f0_q, ibf_q, obf_q};

	// Set wins over clear for both handshake flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reply_q <= 8'h00;
			cmd_q   <= 8'h00;
			obf_q   <= 1'b0;
			ibf_q   <= 1'b0;
			cd_q    <= 1'b0;
		end else begin
			if (op_bufout) begin
				reply_q <= fw_data;
				obf_q   <= 1'b1;
			end else if (rd_done & ~rd_a2_q) begin
				obf_q   <= 1'b0;
			end
			if (wr_done) begin
				cmd_q <= wr_byte_q;
				cd_q  <= wr_a2_q;
				ibf_q <= 1'b1;
			end else if (op_bufin) begin
				ibf_q <= 1'b0;
			end
		end
	end

	// Firmware-owned status bits; host has no path to them
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			f0_q  <= 1'b0;
			usr_q <= 4'h0;
		end else if (fw_op_valid) begin
			if (fw_op == kbchp_pkg::OP_F0CLR) begin
				f0_q <= 1'b0;
			end else if (fw_op == kbchp_pkg::OP_F0CPL) begin
				f0_q <= ~f0_q;
			end else if (fw_op == kbchp_pkg::OP_MOVSTS) begin
				usr_q <= fw_data[7:4];
			end
		end
	end

	// Read data stays live for the whole strobe, status tracks flags
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_dout <= 8'h00;
			host_doe  <= 1'b0;
		end else begin
			host_doe  <= (hs_q == kbchp_pkg::HS_READ) & ~rd_n_s;
			host_dout <= rd_a2_q ? status : reply_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts and program counter

	logic ibf_ie_q;
	logic tmr_ie_q;
	logic tmr_pend_q;
	logic in_svc_q;
	logic ibf_req;
	logic tmr_req;
	logic take;
	logic push;
	logic pop;
	logic op_exit_with_flags_restore;
	logic [7:0] pop_lo;
	logic [7:0] pop_hi;

	assign ibf_req = ibf_q & ibf_ie_q;
	assign tmr_req = tmr_pend_q & tmr_ie_q;
	// Taken only between ops so no op is lost
	assign take    = ~fw_op_valid & ~in_svc_q & (ibf_req | tmr_req);
	assign op_exit_with_flags_restore = fw_op_valid & (fw_op == kbchp_pkg::OP_EXIT_WITH_FLAGS_RESTORE);
	assign push    = take | (fw_op_valid & (fw_op == kbchp_pkg::OP_CALL));
	assign pop     = op_exit_with_flags_restore | (fw_op_valid & (fw_op == kbchp_pkg::OP_RET));

	// Enables, service lock and timer pending (overflow wins)
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ibf_ie_q   <= 1'b0;
			tmr_ie_q   <= 1'b0;
			tmr_pend_q <= 1'b0;
			in_svc_q   <= 1'b0;
			irq_call   <= 1'b0;
		end else begin
			irq_call <= take;
			if (fw_op_valid & fw_op == kbchp_pkg::OP_IBFIE) begin
				ibf_ie_q <= fw_data[0];
			end
			if (fw_op_valid & fw_op == kbchp_pkg::OP_TMRIE) begin
				tmr_ie_q <= fw_data[0];
			end
			if (timer_ovf) begin
				tmr_pend_q <= 1'b1;
			end else if (take & ~ibf_req) begin
				tmr_pend_q <= 1'b0;
			end
			if (take) begin
				in_svc_q <= 1'b1;
			end else if (op_exit_with_flags_restore) begin
				in_svc_q <= 1'b0;
			end
		end
	end

	// Host-write interrupt outranks the timer
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pc <= kbchp_pkg::VEC_RESET;
		end else if (take) begin
			pc <= ibf_req ? kbchp_pkg::VEC_IBF : kbchp_pkg::VEC_TMR;
		end else if (pop) begin
			pc <= {pop_hi[2:0], pop_lo};
		end else if (fw_op_valid & (fw_op == kbchp_pkg::OP_CALL |
			fw_op == kbchp_pkg::OP_JMP)) begin
			pc <= fw_addr;
		end else if (fw_op_valid & fw_op == kbchp_pkg::OP_INCPC) begin
			pc <= pc + 11'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Program state word, data RAM and stack

	logic [7:0] ram [kbchp_pkg::RAM_DEPTH];
	logic [2:0] sp;
	logic [2:0] sp_dec;
	logic [7:0] stk_w;
	logic [7:0] stk_r;
	logic [7:0] reg_addr;

	assign sp     = program_state_word[2:0];
	assign sp_dec = sp - 3'h1;
	assign stk_w  = kbchp_pkg::STACK_BASE + {4'h0, sp, 1'b0};
	assign stk_r  = kbchp_pkg::STACK_BASE + {4'h0, sp_dec, 1'b0};
	assign pop_lo = ram[stk_r];
	assign pop_hi = ram[stk_r + 8'h01];
	assign reg_addr = (program_state_word[kbchp_pkg::PSW_BS] ? kbchp_pkg::BANK1_BASE :
		kbchp_pkg::BANK0_BASE) + {5'h00, fw_addr[2:0]};

	// Reserved bit keeps its reset value
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			program_state_word <= kbchp_pkg::PSW_RST;
		end else if (push) begin
			program_state_word[2:0] <= sp + 3'h1;
		end else if (pop) begin
			program_state_word[2:0] <= sp_dec;
			if (op_exit_with_flags_restore) begin
				program_state_word[7:4] <= pop_hi[7:4];
			end
		end else if (fw_op_valid) begin
			if (fw_op == kbchp_pkg::OP_SELRB0) begin
				program_state_word[kbchp_pkg::PSW_BS] <= 1'b0;
			end else if (fw_op == kbchp_pkg::OP_SELRB1) begin
				program_state_word[kbchp_pkg::PSW_BS] <= 1'b1;
			end else if (fw_op == kbchp_pkg::OP_PSWWR) begin
				program_state_word[7:4] <= fw_data[7:4];
				program_state_word[2:0] <= fw_data[2:0];
			end
		end
	end

	// RAM has no reset; a push stores PC and top state nibble
	always_ff @(posedge sys_clk) begin
		if (push) begin
			ram[stk_w]         <= pc[7:0];
			ram[stk_w + 8'h01] <= {program_state_word[7:kbchp_pkg::PSW_TOP], 1'b0,
				pc[10:8]};
		end else if (fw_op_valid & fw_op == kbchp_pkg::OP_REGWR) begin
			ram[reg_addr] <= fw_data;
		end else if (fw_op_valid & fw_op == kbchp_pkg::OP_RAMWR) begin
			ram[fw_addr[7:0]] <= fw_data;
		end
	end

	// Firmware read-back, held until the next read op
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fw_rdata <= 8'h00;
		end else if (fw_op_valid) begin
			unique case (fw_op)
				kbchp_pkg::OP_BUFIN: fw_rdata <= cmd_q;
				kbchp_pkg::OP_REGRD: fw_rdata <= ram[reg_addr];
				kbchp_pkg::OP_RAMRD: fw_rdata <= ram[fw_addr[7:0]];
				kbchp_pkg::OP_PSWRD: fw_rdata <= program_state_word;
				kbchp_pkg::OP_P1RD:  fw_rdata <= p1_s;
				kbchp_pkg::OP_P2RD:  fw_rdata <= p2_s;
				default:             fw_rdata <= fw_rdata;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port lines and handshake pins

	logic [7:0]  p1_lat_q;
	logic [7:0]  p2_lat_q;
	logic [15:0] hi_q;
	logic        drq_q;
	logic [7:0]  p2_eff;
	logic [15:0] eff_all;

	// Latches, one-cycle strong pull on written ones, mode enables
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			p1_lat_q   <= kbchp_pkg::PORT_RST;
			p2_lat_q   <= kbchp_pkg::PORT_RST;
			hi_q       <= 16'h0000;
			flags_en_q <= 1'b0;
			dma_en_q   <= 1'b0;
		end else begin
			hi_q <= 16'h0000;
			if (fw_op_valid & fw_op == kbchp_pkg::OP_P1WR) begin
				p1_lat_q   <= fw_data;
				hi_q[7:0]  <= fw_data;
			end
			if (fw_op_valid & fw_op == kbchp_pkg::OP_P2WR) begin
				p2_lat_q   <= fw_data;
				hi_q[15:8] <= fw_data;
			end
			if (fw_op_valid & fw_op == kbchp_pkg::OP_ENFLG) begin
				flags_en_q <= 1'b1;
			end
			if (fw_op_valid & fw_op == kbchp_pkg::OP_ENDMA) begin
				dma_en_q <= 1'b1;
			end
		end
	end

	// Acknowledge or a repeated enable aborts the request
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			drq_q <= 1'b0;
		end else if (dack_act |
			(fw_op_valid & fw_op == kbchp_pkg::OP_ENDMA)) begin
			drq_q <= 1'b0;
		end else if (dma_en_q & fw_op_valid &
			fw_op == kbchp_pkg::OP_P2WR & fw_data[kbchp_pkg::P2_DRQ]) begin
			drq_q <= 1'b1;
		end
	end

	// Pin values after the flag and DMA overlays
	always_comb begin
		p2_eff = p2_lat_q;
		if (flags_en_q) begin
			p2_eff[kbchp_pkg::P2_RPL] = p2_lat_q[kbchp_pkg::P2_RPL] &
				obf_q;
			p2_eff[kbchp_pkg::P2_WRF] = p2_lat_q[kbchp_pkg::P2_WRF] &
				~ibf_q;
		end
		if (dma_en_q) begin
			p2_eff[kbchp_pkg::P2_DRQ] = drq_q;
		end
	end

	assign eff_all = {p2_eff, p1_lat_q};

	// Drive low for 0; a written 1 pulls high once then floats
	for (genvar i = 0; i < 16; i++) begin : g_pin
		logic out_q;
		logic oe_q;
		always_ff @(posedge sys_clk or posedge rst) begin
			if (rst) begin
				out_q <= 1'b0;
				oe_q  <= 1'b0;
			end else begin
				out_q <= hi_q[i];
				oe_q  <= hi_q[i] | ~eff_all[i];
			end
		end
		if (i < 8) begin : g_p1
			assign p1_out[i] = out_q;
			assign p1_oe[i]  = oe_q;
		end else begin : g_p2
			assign p2_out[i-8] = out_q;
			assign p2_oe[i-8]  = oe_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence host_wr_s;
		hs_q == kbchp_pkg::HS_WRITE ##1 hs_q == kbchp_pkg::HS_IDLE;
	endsequence

	reply_set_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		op_bufout |=> obf_q && reply_q == $past(fw_data))
		else $error("reply flag or byte not loaded");

	reply_clr_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		rd_done && !rd_a2_q && !op_bufout |=> !obf_q)
		else $error("reply flag not cleared by host read");

	write_flag_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		host_wr_s |-> ibf_q && cmd_q == $past(wr_byte_q))
		else $error("host write did not set write flag");

	cmd_data_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		host_wr_s |-> cd_q == $past(wr_a2_q))
		else $error("command/data flag does not follow A2");

	read_drive_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		hs_q == kbchp_pkg::HS_READ && !rd_n_s ##1 !rd_n_s
		|-> host_doe && host_dout == (rd_a2_q ? $past(status) :
			$past(reply_q)))
		else $error("host read data wrong");

	req_abort_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		dack_act |=> !drq_q
			##1 p2_oe[kbchp_pkg::P2_DRQ])
		else $error("transfer request not dropped");

	ibf_vec_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		take && ibf_req |=> pc == kbchp_pkg::VEC_IBF && irq_call
			&& in_svc_q)
		else $error("host write interrupt vector wrong");

	bank_bit_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		fw_op_valid && fw_op == kbchp_pkg::OP_SELRB1 && !push && !pop
		|=> program_state_word[kbchp_pkg::PSW_BS])
		else $error("bank bit not set");

	port_low_a: assert property (
		@(posedge sys_clk) disable iff (rst)
		fw_op_valid && fw_op == kbchp_pkg::OP_P1WR && !fw_data[0]
		##1 !(fw_op_valid && fw_op == kbchp_pkg::OP_P1WR)
		|=> p1_oe[0] && !p1_out[0])
		else $error("port line not driven low");

endmodule

// file: kbchp_host_model.sv
/*
 * Host processor model: I/O read and write cycles on the host pins.
 * Assumes the bench calls acc() and the port answers per its contract.
 */
`timescale 1ns/1ps

module kbchp_host_model (
	// Clock
	input  wire logic       sys_clk,
	// Host pins
	output logic      [9:0] host_addr,
	output logic            host_aen,
	output logic            host_cs_n,
	output logic            host_ior_n,
	output logic            host_iow_n,
	output logic      [7:0] host_din,
	input  wire logic [7:0] host_dout,
	input  wire logic       host_doe
);
	// Idle bus at time zero
	initial begin
		host_addr = 10'h000;
		host_aen = 1'b0;
		host_cs_n = 1'b1;
		host_ior_n = 1'b1;
		host_iow_n = 1'b1;
		host_din = 8'h00;
	end

	////////////////////////////////////////////////////////////////////
	// One access; strobe held 6 cycles, well over the 4-cycle minimum
	task automatic acc(input logic wr, input logic [9:0] a,
		input logic sel_n, input logic [7:0] d, output logic [7:0] q);
		@(negedge sys_clk);
		host_addr = a;
		host_cs_n = sel_n;
		host_din = d;
		host_iow_n = ~wr;
		host_ior_n = wr;
		repeat (6) @(posedge sys_clk);
		// Sample at the falling edge, where read data has settled
		@(negedge sys_clk);
		q = (host_doe === 1'b1) ? host_dout : 8'hXX;
		host_iow_n = 1'b1;
		host_ior_n = 1'b1;
		host_cs_n = 1'b1;
		host_din = ~d; // Released bus shows no stale byte
		repeat (6) @(negedge sys_clk);
	endtask
endmodule

// file: tb_kbc_host_port_and_core_state.sv
/*
 * Bench for the host port: host cycles through the host model,
 * firmware ops through fw(). Assumes pins have external pull-ups.
 */
`timescale 1ns/1ps

module tb_kbc_host_port_and_core_state;
	logic        sys_clk, rst, cs_decode_en, fw_op_valid, timer_ovf;
	logic [10:0] fw_addr;
	logic [7:0]  fw_data, ext_p1, ext_p2, q;
	logic [9:0]  host_addr;
	logic        host_aen, host_cs_n, host_ior_n, host_iow_n, host_doe;
	logic [7:0]  host_din, host_dout, fw_rdata, program_state_word;
	logic [7:0]  p1_out, p1_oe, p2_out, p2_oe;
	logic [10:0] pc, n_irq;
	logic        irq_call;
	int          failures, n_checks, cyc;
	kbchp_pkg::kbchp_op_type fw_op;
	// Pin levels: driven value, else outside level over a pull-up
	wire  [7:0]  p1_in = (p1_oe & p1_out) | (~p1_oe & ext_p1);
	wire  [7:0]  p2_in = (p2_oe & p2_out) | (~p2_oe & ext_p2);

	kbchp_host_port dut (.sys_clk, .rst, .host_addr, .host_aen,
		.host_cs_n, .host_ior_n, .host_iow_n, .host_din, .host_dout,
		.host_doe, .cs_decode_en, .fw_op_valid, .fw_op, .fw_addr,
		.fw_data, .fw_rdata, .pc, .program_state_word, .irq_call, .timer_ovf,
		.p1_in, .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe);
	kbchp_host_model host (.sys_clk, .host_addr, .host_aen, .host_cs_n,
		.host_ior_n, .host_iow_n, .host_din, .host_dout, .host_doe);

	////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		// Count interrupt call pulses
		if (irq_call === 1'b1) begin
			n_irq <= n_irq + 11'h001;
		end
		if (cyc == 6000) begin
			failures = failures + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h",
				$time, got, exp);
		end
	endtask

	// One firmware op, then time for pin outputs to settle
	task automatic fw(input kbchp_pkg::kbchp_op_type op,
		input logic [10:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		fw_op_valid = 1'b1;
		fw_op = op;
		fw_addr = a;
		fw_data = d;
		@(negedge sys_clk);
		fw_op_valid = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask

	// Selected host access; a2 picks 060h or 064h
	task automatic hio(input logic wr, input logic a2, input logic [7:0] d);
		host.acc(wr, {7'h0C, a2, 2'b00}, 1'b0, d, q);
	endtask

	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst, cs_decode_en, fw_op_valid, timer_ovf} = 4'b1000;
		{fw_addr, fw_data, ext_p1, ext_p2} = {11'h000, 8'h00, 16'hFFFF};
		fw_op = kbchp_pkg::OP_NOP;
		{failures, n_checks, cyc} = '0;
		n_irq = 11'h000;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(pc, 11'h000);
		chk(program_state_word, 8'h08);
		chk(p1_oe, 8'h00);
		hio(0, 1, 0); chk(q, 8'h00);
		// Reply path
		fw(kbchp_pkg::OP_BUFOUT, 0, 8'hA5);
		hio(0, 1, 0); chk(q, 8'h01);
		hio(0, 0, 0); chk(q, 8'hA5);
		hio(0, 1, 0); chk(q, 8'h00);
		// Command then data writes
		hio(1, 1, 8'h3C); hio(0, 1, 0); chk(q, 8'h0A);
		fw(kbchp_pkg::OP_BUFIN, 0, 0); chk(fw_rdata, 8'h3C);
		hio(0, 1, 0); chk(q, 8'h08);
		hio(1, 0, 8'h77); hio(0, 1, 0); chk(q, 8'h02);
		fw(kbchp_pkg::OP_BUFIN, 0, 0); chk(fw_rdata, 8'h77);
		// Unselected write ignored, then internal decode
		host.acc(1, 10'h064, 1, 8'h11, q);
		hio(0, 1, 0); chk(q, 8'h00);
		cs_decode_en = 1'b1;
		host.acc(1, 10'h064, 1, 8'h22, q);
		fw(kbchp_pkg::OP_BUFIN, 0, 0); chk(fw_rdata, 8'h22);
		cs_decode_en = 1'b0;
		// Firmware flags
		fw(kbchp_pkg::OP_F0CPL, 0, 0);
		fw(kbchp_pkg::OP_MOVSTS, 0, 8'hA0);
		hio(0, 1, 0); chk(q, 8'hAC);
		// Flag pins: reply flag low forces pin 24 low
		fw(kbchp_pkg::OP_ENFLG, 0, 0);
		fw(kbchp_pkg::OP_P2WR, 0, 8'hFF); chk(p2_oe[5:4], 2'b01);
		fw(kbchp_pkg::OP_BUFOUT, 0, 8'h5A); chk(p2_oe[5:4], 2'b00);
		hio(0, 0, 0); chk(q, 8'h5A);
		// Transfer request, ack, abort
		fw(kbchp_pkg::OP_ENDMA, 0, 0);
		fw(kbchp_pkg::OP_P2WR, 0, 8'hFF); chk(p2_oe[6], 1'b0);
		ext_p2 = 8'h7F;
		repeat (4) @(negedge sys_clk);
		chk(p2_oe[6], 1'b1);
		// Ack and pin levels need two edges to pass the synchroniser
		ext_p2 = 8'hFF;
		ext_p1 = 8'hC3;
		repeat (2) @(negedge sys_clk);
		fw(kbchp_pkg::OP_P2WR, 0, 8'hFF); chk(p2_oe[6], 1'b0);
		fw(kbchp_pkg::OP_ENDMA, 0, 0); chk(p2_oe[6], 1'b1);
		// Quasi-bidirectional port one
		fw(kbchp_pkg::OP_P1RD, 0, 0); chk(fw_rdata, 8'hC3);
		fw(kbchp_pkg::OP_P1WR, 0, 8'h0F); chk(p1_oe, 8'hF0);
		repeat (2) @(negedge sys_clk);
		fw(kbchp_pkg::OP_P1RD, 0, 0); chk(fw_rdata, 8'h03);
		// Register banks
		fw(kbchp_pkg::OP_SELRB1, 0, 0); chk(program_state_word, 8'h18);
		fw(kbchp_pkg::OP_REGWR, 0, 8'h5A);
		fw(kbchp_pkg::OP_RAMRD, 11'h018, 0); chk(fw_rdata, 8'h5A);
		fw(kbchp_pkg::OP_SELRB0, 0, 0); chk(program_state_word, 8'h08);
		// Call and flag-restoring exit
		fw(kbchp_pkg::OP_PSWWR, 0, 8'hE0); chk(program_state_word, 8'hE8);
		fw(kbchp_pkg::OP_CALL, 11'h123, 0); chk(pc, 11'h123);
		chk(program_state_word, 8'hE9);
		fw(kbchp_pkg::OP_RAMRD, 11'h009, 0); chk(fw_rdata, 8'hE0);
		fw(kbchp_pkg::OP_PSWWR, 0, 8'h01);
		fw(kbchp_pkg::OP_EXIT_WITH_FLAGS_RESTORE, 0, 0); chk(program_state_word, 8'hE8);
		// Interrupt calls
		fw(kbchp_pkg::OP_IBFIE, 0, 8'h01);
		hio(1, 0, 8'h55); chk(pc, 11'h003);
		fw(kbchp_pkg::OP_BUFIN, 0, 0);
		fw(kbchp_pkg::OP_EXIT_WITH_FLAGS_RESTORE, 0, 0); chk(pc, 11'h000);
		fw(kbchp_pkg::OP_TMRIE, 0, 8'h01);
		timer_ovf = 1'b1;
		@(negedge sys_clk);
		timer_ovf = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk(pc, 11'h007);
		chk(n_irq, 11'h002);
		report_and_stop();
	end
endmodule
